// ---- asp_pkg.sv ----
// constants shared by both ends of the converter serial port
// assumes one 100 MHz system clock on each end
package asp_pkg;
  localparam int SYS_HZ         = 100_000_000;
  localparam int CYC_PER_US     = SYS_HZ / 1_000_000;
  localparam int RESET_WAIT_US  = 200;
  localparam int WAKE_US        = 200;
  localparam int RESET_WAIT_CYC = RESET_WAIT_US * CYC_PER_US;
  localparam int WAKE_CYC       = WAKE_US * CYC_PER_US;
  localparam int ONES_FOR_RESET = 40;

  // command byte fields
  localparam int CMD_WEN_BIT   = 7;
  localparam int CMD_RW_BIT    = 6;
  localparam int CMD_RS_MSB    = 5;
  localparam int CMD_RS_LSB    = 3;
  localparam int CMD_CREAD_BIT = 2;
  localparam logic [7:0] CMD_CREAD_ENTER = 8'h5C;
  localparam logic [7:0] CMD_CREAD_EXIT  = 8'h58;

  // device registers
  localparam logic [2:0]  REG_STATUS = 3'h0;
  localparam logic [2:0]  REG_MODE   = 3'h1;
  localparam logic [2:0]  REG_DATA   = 3'h3;
  localparam logic [23:0] MODE_RESET = 24'h000000;
  localparam logic [3:0]  CHAN_RESET = 4'h0;
  localparam int OPM_MSB    = 23;
  localparam int OPM_LSB    = 21;
  localparam int APPEND_BIT = 20;
  localparam logic [2:0] OPM_CONT   = 3'h0;
  localparam logic [2:0] OPM_SINGLE = 3'h1;
  localparam logic [2:0] OPM_PWRDN  = 3'h3;
  localparam logic [5:0] LEN_BYTE = 6'h08;
  localparam logic [5:0] LEN_WORD = 6'h18;
  localparam logic [5:0] LEN_APP  = 6'h20;

  // host controller registers
  localparam logic [2:0] HA_CTRL   = 3'h0;
  localparam logic [2:0] HA_WDATA  = 3'h1;
  localparam logic [2:0] HA_RDATA  = 3'h2;
  localparam logic [2:0] HA_STATUS = 3'h3;
  localparam logic [2:0] HA_CONFIG = 3'h4;
  localparam int CTRL_NB_LSB   = 8;
  localparam int CTRL_NB_MSB   = 13;
  localparam int CTRL_SKIP_BIT = 16;
  localparam int CFG_KEEPCS_BIT = 0;
  localparam int CFG_DINHI_BIT  = 1;
  localparam int SCLK_HALF      = 8;

  typedef enum {PH_CMD, PH_WR, PH_RD} asp_phase_t;
  typedef enum {H_GUARD, H_IDLE, H_SETUP, H_LOW, H_HIGH, H_END} asp_hstate_t;
endpackage

// ---- asp_if.sv ----
// four-line serial link between host and converter port
// dout is only valid while dout_oe is high; the bench resolves the wire
`timescale 1ns/100ps
interface asp_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  modport dev  (input cs_n, input sclk, input din, output dout, output dout_oe);
  modport host (output cs_n, output sclk, output din, input dout);
endinterface

// ---- asp_sync.sv ----
// two-flop synchroniser, one per bit
// assumes inputs asynchronous to clk
`timescale 1ns/100ps
module asp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        meta[i] <= d[i];
        q[i]    <= meta[i];
      end
    end
  endgenerate
endmodule // asp_sync

// ---- asp_dev.sv ----
// converter end of the serial port: command decode, registers, data ready
// assumes converter core on SYS_CLK handing words via CONV_DONE
// Functional notes
// - after any reset, next byte is command
// - command picks read/write and target register
// - data in on din, out on dout
// - ready low on new word, high after read
// - ready raised before data register update
// - select qualifies device; may be tied low
// - data word rereadable until next update
// - continuous read delivers each word once
// - select fall presents ready level immediately
// - 40 ones reset interface and registers
// - host waits 200 us after reset
// - host idles serial clock high
// - single code converts once then powers down
// - single conversion waits 200 us wakeup
// - single mode ready low on done
// - append status after data when enabled
// - continuous conversion default; pin gated by select
// - busy data read discards new word
// - 0x5C enters continuous read
// - unread word replaced by newer one
// - 0x58 while ready low exits
// - host keeps din low in continuous read
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/100ps
module asp_dev #(
  parameter int WAKE_CYCLES = asp_pkg::WAKE_CYC
) (
  // system
  input  wire logic        SYS_CLK,
  input  wire logic        SRST,
  // link
  asp_if.dev               LINK,
  // converter core
  input  wire logic        CONV_DONE,
  input  wire logic [23:0] CONV_DATA,
  input  wire logic [3:0]  CONV_CHAN,
  output logic             CONV_RUN,
  output logic             CONV_START,
  output logic             CONV_CLEAR
);
  logic [2:0]  pin_s;
  logic        cs_n_s, sclk_s, din_s, sclk_d;
  asp_pkg::asp_phase_t phase;
  logic [5:0]  bit_cnt;
  logic [23:0] in_sh;
  logic [32:0] out_sh;
  logic [2:0]  cur_rs;
  logic        rd_data;
  logic [23:0] mode_reg, data_reg, pend_data;
  logic [3:0]  chan_reg, pend_chan;
  logic        rdy_n, cread, upd_pend, soft_rst, dout_q;
  logic [5:0]  ones_cnt;
  logic [2:0]  watch_cnt;
  logic [31:0] wake_cnt;
  logic        waking;

  asp_sync #(.W(3)) u_sync (
    .clk (SYS_CLK),
    .d   ({LINK.cs_n, LINK.sclk, LINK.din}),
    .q   (pin_s)
  );
  assign {cs_n_s, sclk_s, din_s} = pin_s;

  // edges count only while selected
  wire sel     = ~cs_n_s;
  wire rise    = sel & sclk_s & ~sclk_d;
  wire fall    = sel & ~sclk_s & sclk_d;
  wire rst_all = SRST | soft_rst;
  wire [7:0] in_byte = {in_sh[6:0], din_s};
  wire [23:0] in_word = {in_sh[22:0], din_s};
  wire [2:0] opm     = mode_reg[asp_pkg::OPM_MSB:asp_pkg::OPM_LSB];
  wire append        = mode_reg[asp_pkg::APPEND_BIT];
  wire [7:0] status  = {rdy_n, 3'h0, chan_reg};
  wire [2:0] cmd_rs  = in_byte[asp_pkg::CMD_RS_MSB:asp_pkg::CMD_RS_LSB];
  wire cmd_ok        = ~in_byte[asp_pkg::CMD_WEN_BIT];
  wire cmd_rd        = in_byte[asp_pkg::CMD_RW_BIT];
  wire cmd_cread     = cmd_rd & (cmd_rs == asp_pkg::REG_DATA)
                       & in_byte[asp_pkg::CMD_CREAD_BIT];
  wire byte_done     = rise & (bit_cnt == 6'h01);
  wire out_done      = rise & (bit_cnt == 6'h01);  // host makes no fall after the last bit
  // a data read in progress blocks the new word outside continuous read
  wire discard       = ~cread & (phase == asp_pkg::PH_RD) & rd_data;
  wire exit_seen     = cread & rise & (watch_cnt == 3'h7)
                       & (in_byte == asp_pkg::CMD_CREAD_EXIT) & ~rdy_n;
  wire mode_wr       = byte_done & (phase == asp_pkg::PH_WR)
                       & (cur_rs == asp_pkg::REG_MODE);
  wire show_data     = (phase == asp_pkg::PH_RD) & ~(upd_pend & cread);

  // msb-aligned read value and length of the addressed register
  logic [31:0] rd_val;
  logic [5:0]  rd_len;
  always_comb begin
    case (cmd_rs)
      asp_pkg::REG_STATUS: begin
        rd_val = {status, 24'h000000};
        rd_len = asp_pkg::LEN_BYTE;
      end
      asp_pkg::REG_MODE: begin
        rd_val = {mode_reg, 8'h00};
        rd_len = asp_pkg::LEN_WORD;
      end
      asp_pkg::REG_DATA: begin
        rd_val = {data_reg, append ? status : 8'h00};
        rd_len = append ? asp_pkg::LEN_APP : asp_pkg::LEN_WORD;
      end
      default: begin
        rd_val = 32'h00000000;
        rd_len = asp_pkg::LEN_BYTE;
      end
    endcase
  end
  wire [31:0] conv_val = {pend_data, append ? {rdy_n, 3'h0, pend_chan} : 8'h00};
  wire [5:0]  conv_len = append ? asp_pkg::LEN_APP : asp_pkg::LEN_WORD;

  always_ff @(posedge SYS_CLK) begin
    sclk_d <= sclk_s;
  end

  // forty consecutive ones while selected reset everything
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= rise & din_s
                  & (ones_cnt == 6'(asp_pkg::ONES_FOR_RESET - 1));
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (rst_all) begin
      ones_cnt <= 6'h00;
    end else if (rise) begin
      ones_cnt <= din_s ? ones_cnt + 6'h01 : 6'h00;
    end
  end

  // serial engine: command, write and read phases
  always_ff @(posedge SYS_CLK) begin
    if (rst_all || !sel) begin
      phase   <= asp_pkg::PH_CMD;
      bit_cnt <= asp_pkg::LEN_BYTE;
      rd_data <= 1'b0;
      in_sh   <= 24'h000000;
      cur_rs  <= asp_pkg::REG_STATUS;
    end else begin
      if (rise) begin
        in_sh <= in_word;
      end
      case (phase)
        asp_pkg::PH_CMD: begin
          if (rise) begin
            bit_cnt <= bit_cnt - 6'h01;
          end
          if (byte_done) begin
            bit_cnt <= asp_pkg::LEN_BYTE;
            cur_rs  <= cmd_rs;
            if (cmd_ok && cmd_rd && !cmd_cread && !cread) begin
              phase   <= asp_pkg::PH_RD;
              bit_cnt <= rd_len + 6'h01;
              rd_data <= (cmd_rs == asp_pkg::REG_DATA);
            end else if (cmd_ok && !cmd_rd && !cread) begin
              phase   <= asp_pkg::PH_WR;
              bit_cnt <= (cmd_rs == asp_pkg::REG_STATUS) ? asp_pkg::LEN_BYTE
                         : asp_pkg::LEN_WORD;
            end
          end
        end
        asp_pkg::PH_WR: begin
          if (rise) begin
            bit_cnt <= bit_cnt - 6'h01;
          end
          if (byte_done) begin
            phase   <= asp_pkg::PH_CMD;
            bit_cnt <= asp_pkg::LEN_BYTE;
          end
        end
        asp_pkg::PH_RD: begin
          if (fall) begin
            bit_cnt <= bit_cnt - 6'h01;
          end
          if (out_done || exit_seen) begin
            phase   <= asp_pkg::PH_CMD;
            bit_cnt <= asp_pkg::LEN_BYTE;
            rd_data <= 1'b0;
          end
        end
        default: phase <= asp_pkg::PH_CMD;
      endcase
      // continuous read: newest word replaces whatever was shifting
      if (upd_pend && cread) begin
        phase   <= asp_pkg::PH_RD;
        bit_cnt <= conv_len + 6'h01;
        rd_data <= 1'b1;
      end
    end
  end

  // lead bit before the first fall: low ahead of a continuous-read word, high ahead of any command-started read, data register included
  always_ff @(posedge SYS_CLK) begin
    if (rst_all) begin
      out_sh <= 33'h000000000;
    end else if (upd_pend && cread) begin
      out_sh <= {1'b0, conv_val};
    end else if (byte_done && phase == asp_pkg::PH_CMD) begin
      out_sh <= {1'b1, rd_val};
    end else if (fall && phase == asp_pkg::PH_RD) begin
      out_sh <= {out_sh[31:0], 1'b0};
    end
  end

  // continuous-read watch on din, byte aligned from entry
  always_ff @(posedge SYS_CLK) begin
    if (rst_all || !cread || !sel) begin
      watch_cnt <= 3'h0;
    end else if (rise) begin
      watch_cnt <= watch_cnt + 3'h1;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (rst_all) begin
      cread <= 1'b0;
    end else if (exit_seen) begin
      cread <= 1'b0;
    end else if (byte_done && phase == asp_pkg::PH_CMD && cmd_ok && cmd_cread) begin
      cread <= 1'b1;
    end
  end

  // two-step update: ready high first, then the new word and ready low
  always_ff @(posedge SYS_CLK) begin
    if (rst_all) begin
      upd_pend  <= 1'b0;
      pend_data <= 24'h000000;
      pend_chan <= asp_pkg::CHAN_RESET;
      data_reg  <= 24'h000000;
      chan_reg  <= asp_pkg::CHAN_RESET;
      rdy_n     <= 1'b1;
    end else begin
      upd_pend <= CONV_DONE & ~discard;
      if (out_done && rd_data) begin
        rdy_n <= 1'b1;
      end
      if (CONV_DONE && !discard) begin
        pend_data <= CONV_DATA;
        pend_chan <= CONV_CHAN;
        rdy_n     <= 1'b1;
      end else if (upd_pend) begin
        data_reg <= pend_data;
        chan_reg <= pend_chan;
        rdy_n    <= 1'b0;
      end
    end
  end

  // mode register and single-conversion sequencing
  always_ff @(posedge SYS_CLK) begin
    if (rst_all) begin
      mode_reg <= asp_pkg::MODE_RESET;
    end else if (mode_wr) begin
      mode_reg <= in_word;
    end else if (upd_pend && opm == asp_pkg::OPM_SINGLE) begin
      mode_reg[asp_pkg::OPM_MSB:asp_pkg::OPM_LSB] <= asp_pkg::OPM_PWRDN;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (rst_all) begin
      waking     <= 1'b0;
      wake_cnt   <= 32'h00000000;
      CONV_START <= 1'b0;
    end else begin
      CONV_START <= waking & (wake_cnt == 32'h00000001);
      if (mode_wr && in_word[asp_pkg::OPM_MSB:asp_pkg::OPM_LSB] == asp_pkg::OPM_SINGLE) begin
        waking   <= 1'b1;
        wake_cnt <= 32'(WAKE_CYCLES);
      end else if (waking) begin
        wake_cnt <= wake_cnt - 32'h00000001;
        waking   <= (wake_cnt != 32'h00000001);
      end
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      CONV_RUN   <= 1'b0;
      CONV_CLEAR <= 1'b1;
    end else begin
      CONV_RUN   <= (opm == asp_pkg::OPM_CONT) & ~soft_rst;
      CONV_CLEAR <= soft_rst | mode_wr;
    end
  end

  // dout shows shifted data during a read, else the ready level
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      dout_q <= 1'b1;
    end else begin
      dout_q <= show_data ? out_sh[32] : rdy_n;
    end
  end
  assign LINK.dout    = dout_q;
  assign LINK.dout_oe = sel;
endmodule // asp_dev

// ---- asp_host.sv ----
// host end: register-driven serial master that makes the link clock
// assumes software on SYS_CLK using the plain register port
`timescale 1ns/100ps
module asp_host #(
  parameter int RESET_WAIT = asp_pkg::RESET_WAIT_CYC,
  parameter int HALF       = asp_pkg::SCLK_HALF
) (
  // system
  input  wire logic        SYS_CLK,
  input  wire logic        SRST,
  // register port
  input  wire logic [2:0]  HOST_ADDR,
  input  wire logic [31:0] HOST_WDATA,
  input  wire logic        HOST_WR,
  input  wire logic        HOST_RD,
  output logic      [31:0] HOST_RDATA,
  // link
  asp_if.host              LINK
);
  asp_pkg::asp_hstate_t st;
  logic [31:0] wdata, guard_cnt;
  logic [39:0] tx;
  logic [31:0] rx;
  logic [6:0]  left;
  logic [7:0]  div;
  logic [5:0]  ones_run;
  logic        keep_cs, din_hi, sclk_q, cs_n_q, din_q, dout_s, lost_ones;

  asp_sync #(.W(1)) u_sync (
    .clk (SYS_CLK),
    .d   (LINK.dout),
    .q   (dout_s)
  );

  wire go      = HOST_WR & (HOST_ADDR == asp_pkg::HA_CTRL) & (st == asp_pkg::H_IDLE);
  wire skip    = HOST_WDATA[asp_pkg::CTRL_SKIP_BIT];
  wire [5:0] nb = HOST_WDATA[asp_pkg::CTRL_NB_MSB:asp_pkg::CTRL_NB_LSB];
  wire tick    = (div == 8'(HALF - 1));
  wire busy    = (st != asp_pkg::H_IDLE);
  logic [31:0] rd_mux;
  always_comb begin
    case (HOST_ADDR)
      asp_pkg::HA_WDATA:  rd_mux = wdata;
      asp_pkg::HA_RDATA:  rd_mux = rx;
      asp_pkg::HA_STATUS: rd_mux = {29'h00000000, st == asp_pkg::H_GUARD, dout_s, busy};
      asp_pkg::HA_CONFIG: rd_mux = {30'h00000000, din_hi, keep_cs};
      default:            rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      HOST_RDATA <= 32'h00000000;
      wdata      <= 32'h00000000;
      keep_cs    <= 1'b0;
      din_hi     <= 1'b0;
    end else begin
      HOST_RDATA <= HOST_RD ? rd_mux : 32'h00000000;
      if (HOST_WR && HOST_ADDR == asp_pkg::HA_WDATA) begin
        wdata <= HOST_WDATA;
      end
      if (HOST_WR && HOST_ADDR == asp_pkg::HA_CONFIG) begin
        keep_cs <= HOST_WDATA[asp_pkg::CFG_KEEPCS_BIT];
        din_hi  <= HOST_WDATA[asp_pkg::CFG_DINHI_BIT];
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST || st == asp_pkg::H_IDLE || tick) begin
      div <= 8'h00;
    end else begin
      div <= div + 8'h01;
    end
  end

  // transfer sequencer: fall drives din, rise samples dout
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      st        <= asp_pkg::H_GUARD;
      guard_cnt <= 32'(RESET_WAIT);
      sclk_q    <= 1'b1;
      cs_n_q    <= 1'b1;
      din_q     <= 1'b0;
      tx        <= 40'h0000000000;
      rx        <= 32'h00000000;
      left      <= 7'h00;
      ones_run  <= 6'h00;
      lost_ones <= 1'b0;
    end else begin
      case (st)
        asp_pkg::H_GUARD: begin
          guard_cnt <= guard_cnt - 32'h00000001;
          if (guard_cnt == 32'h00000001) begin
            st <= asp_pkg::H_IDLE;
          end
        end
        asp_pkg::H_IDLE: begin
          if (go) begin
            st     <= asp_pkg::H_SETUP;
            cs_n_q <= 1'b0;
            tx     <= skip ? {wdata, 8'h00} : {HOST_WDATA[7:0], wdata};
            left   <= 7'(nb) + (skip ? 7'h00 : 7'h08);
            rx     <= 32'h00000000;
          end
        end
        asp_pkg::H_SETUP: begin
          if (tick) begin
            st     <= (left == 7'h00) ? asp_pkg::H_END : asp_pkg::H_LOW;
            sclk_q <= (left == 7'h00);
            din_q  <= tx[39];
            tx     <= {tx[38:0], 1'b0};
            ones_run <= tx[39] ? ones_run + 6'h01 : 6'h00;
            if (tx[39] && ones_run == 6'(asp_pkg::ONES_FOR_RESET - 1)) begin
              lost_ones <= 1'b1;
            end
          end
        end
        asp_pkg::H_LOW: begin
          if (tick) begin
            st     <= asp_pkg::H_HIGH;
            sclk_q <= 1'b1;
            rx     <= {rx[30:0], dout_s};
            left   <= left - 7'h01;
          end
        end
        asp_pkg::H_HIGH: begin
          st <= asp_pkg::H_SETUP;
        end
        asp_pkg::H_END: begin
          cs_n_q <= ~keep_cs;
          din_q  <= din_hi;
          if (lost_ones) begin
            st        <= asp_pkg::H_GUARD;
            guard_cnt <= 32'(RESET_WAIT);
            lost_ones <= 1'b0;
            ones_run  <= 6'h00;
          end else begin
            st <= asp_pkg::H_IDLE;
          end
        end
        default: st <= asp_pkg::H_IDLE;
      endcase
    end
  end

  assign LINK.sclk = sclk_q;
  assign LINK.cs_n = cs_n_q;
  assign LINK.din  = din_q;
endmodule // asp_host

// ---- asp_properties.sv ----
// timing checks on the device-side link wires and converter-core pins
// assumes the bench places it beside the link joining both ends
`timescale 1ns/100ps
module asp_properties (
  // system
  input wire logic SYS_CLK,
  input wire logic SRST,
  // link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  // converter core
  input wire logic CONV_DONE,
  input wire logic CONV_RUN,
  input wire logic CONV_START,
  input wire logic CONV_CLEAR
);
  logic       sclk_q;
  logic [5:0] ones;
  logic [5:0] hi_cnt;
  wire        sclk_rise = sclk && !sclk_q;
  wire        link_idle = (hi_cnt > 6'h14);
  wire        fortieth  = sclk_rise && din && !cs_n && (ones == 6'h27);

  // ones counted on raw link edges, ahead of the device's own sampling
  always_ff @(posedge SYS_CLK) begin
    sclk_q <= sclk;
    if (SRST || cs_n || (sclk_rise && !din))
      ones <= 6'h00;
    else if (sclk_rise && ones != 6'h3F)
      ones <= ones + 6'h01;
    if (SRST || !sclk)
      hi_cnt <= 6'h00;
    else if (hi_cnt != 6'h3F)
      hi_cnt <= hi_cnt + 6'h01;
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  sequence s_update;
    dout ##[1:6] !dout;
  endsequence
  sequence s_soft_reset;
    CONV_CLEAR ##[0:6] CONV_RUN;
  endsequence

  a_reset_values: assert property (
    $fell(SRST) |-> cs_n && sclk && !din && CONV_CLEAR && !CONV_RUN)
    else $error("link or core pins not at reset level");
  a_sclk_idle_high: assert property (
    cs_n |-> sclk)
    else $error("link clock low while deselected");
  a_oe_off_deselect: assert property (
    cs_n [*5] |-> !dout_oe)
    else $error("output driven while deselected");
  a_oe_on_select: assert property (
    !cs_n [*5] |-> dout_oe)
    else $error("output released while selected");
  a_ready_on_update: assert property (
    CONV_DONE && dout_oe && link_idle |-> ##[1:3] s_update)
    else $error("ready not raised then lowered around update");
  a_start_single_mode: assert property (
    CONV_START |-> !CONV_RUN)
    else $error("single start while continuous");
  a_start_one_pulse: assert property (
    $rose(CONV_START) |=> !CONV_START)
    else $error("start longer than one cycle");
  a_ones_soft_reset: assert property (
    fortieth |-> ##[1:12] s_soft_reset)
    else $error("forty ones did not reset the device");
endmodule // asp_properties

// ---- tb_top.sv ----
// bench: host and converter ends joined over the serial link, with a word model
// assumes one 100 MHz clock for both ends; released data line pulled high here
`timescale 1ns/100ps
module tb_top;
  localparam int WAIT = 50;
  logic        sys_clk    = 1'b0;
  logic        srst       = 1'b1;
  logic [2:0]  addr       = 3'h0;
  logic [31:0] wdata      = 32'h0;
  logic        wr_s       = 1'b0;
  logic        rd_s       = 1'b0;
  logic [31:0] host_rdata;
  logic        conv_done  = 1'b0;
  logic [23:0] conv_data  = 24'h0;
  logic [3:0]  conv_chan  = 4'h0;
  logic        conv_run;
  logic        conv_start;
  logic        conv_clear;
  logic [31:0] rdat;
  logic [31:0] x          = 32'h8DC2;
  logic [23:0] exp_word;
  logic [3:0]  exp_chan;
  int          fail_count = 0;
  int          compares   = 0;
  int          n;

  asp_if dl ();
  asp_if hl ();
  assign dl.cs_n = hl.cs_n;
  assign dl.sclk = hl.sclk;
  assign dl.din  = hl.din;
  assign hl.dout = dl.dout_oe ? dl.dout : 1'b1;
  assign hl.dout_oe = dl.dout_oe;

  always #5 sys_clk = ~sys_clk;

  asp_host #(.RESET_WAIT(WAIT)) i_asp_host (.SYS_CLK(sys_clk), .SRST(srst), .HOST_ADDR(addr),
    .HOST_WDATA(wdata), .HOST_WR(wr_s), .HOST_RD(rd_s), .HOST_RDATA(host_rdata), .LINK(hl.host));
  asp_dev #(.WAKE_CYCLES(WAIT)) i_asp_dev (.SYS_CLK(sys_clk), .SRST(srst), .LINK(dl.dev),
    .CONV_DONE(conv_done), .CONV_DATA(conv_data), .CONV_CHAN(conv_chan), .CONV_RUN(conv_run),
    .CONV_START(conv_start), .CONV_CLEAR(conv_clear));
  asp_properties i_asp_properties (.SYS_CLK(sys_clk), .SRST(srst), .cs_n(dl.cs_n),
    .sclk(dl.sclk), .din(dl.din), .dout(dl.dout), .dout_oe(dl.dout_oe), .CONV_DONE(conv_done),
    .CONV_RUN(conv_run), .CONV_START(conv_start), .CONV_CLEAR(conv_clear));

  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (fail_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge sys_clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    #1 rdat = host_rdata;
  endtask

  task automatic xfer(input logic [7:0] cmd, input logic [5:0] nb, input logic [31:0] d,
                      input logic skip);
    wr(asp_pkg::HA_WDATA, d);
    wr(asp_pkg::HA_CTRL, {15'h0, skip, 2'h0, nb, cmd});
    repeat (1000) begin
      rd(asp_pkg::HA_STATUS);
      if (rdat[0] !== 1'b1)
        break;
    end
    chk(rdat[0], 1'b0);
    rd(asp_pkg::HA_RDATA);
  endtask

  // keep low means the word is expected to be lost
  task automatic conv(input logic keep);
    logic [31:0] r;
    r = rnd();
    repeat (30) @(posedge sys_clk);
    conv_data <= r[23:0];
    conv_chan <= r[27:24];
    conv_done <= 1'b1;
    if (keep) begin
      exp_word = r[23:0];
      exp_chan = r[27:24];
    end
    @(posedge sys_clk);
    conv_done <= 1'b0;
    repeat (20) @(posedge sys_clk);
  endtask

  task automatic rdw(input logic skip);
    xfer(8'h58, 6'h20, 32'h0, skip);
    chk(rdat[31:8], exp_word);
    chk(rdat[3:0], exp_chan);
  endtask

  initial begin
    #1_000_000;
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    rd(asp_pkg::HA_STATUS);
    chk(rdat[2], 1'b1);
    repeat (WAIT) @(posedge sys_clk);
    rd(asp_pkg::HA_STATUS);
    chk(rdat[2], 1'b0);
    wr(asp_pkg::HA_CONFIG, 32'h1);
    xfer(8'h08, 6'h18, 32'h10000000, 1'b0);
    xfer(8'h48, 6'h18, 32'h0, 1'b0);
    chk(rdat[23:0], 24'h100000);
    conv(1'b1);
    rd(asp_pkg::HA_STATUS);
    chk(rdat[1], 1'b0);
    repeat (2) begin
      rdw(1'b0);
      rd(asp_pkg::HA_STATUS);
      chk(rdat[1], 1'b1);
    end
    // word arriving mid-read must be dropped
    fork
      xfer(8'h58, 6'h20, 32'h0, 1'b0);
      begin
        repeat (150) @(posedge sys_clk);
        conv(1'b0);
      end
    join
    rdw(1'b0);
    xfer(asp_pkg::CMD_CREAD_ENTER, 6'h00, 32'h0, 1'b0);
    conv(1'b1);
    conv(1'b1);
    rdw(1'b1);
    rd(asp_pkg::HA_STATUS);
    chk(rdat[1], 1'b1);
    conv(1'b1);
    xfer(asp_pkg::CMD_CREAD_EXIT, 6'h00, 32'h0, 1'b0);
    rdw(1'b0);
    xfer(8'h08, 6'h18, 32'h30000000, 1'b0);
    n = 0;
    while (conv_start !== 1'b1 && n < 500) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n >= WAIT - 20 && n <= WAIT, 1'b1);
    chk(conv_run, 1'b0);
    conv(1'b1);
    rdw(1'b0);
    rd(asp_pkg::HA_STATUS);
    chk(rdat[1], 1'b1);
    // select is only released at the end of the next transfer
    wr(asp_pkg::HA_CONFIG, 32'h0);
    xfer(8'h48, 6'h18, 32'h0, 1'b0);
    chk(rdat[23:21], asp_pkg::OPM_PWRDN);
    repeat (20) @(posedge sys_clk);
    chk(dl.dout_oe, 1'b0);
    rdw(1'b0);
    xfer(8'hFF, 6'h20, 32'hFFFFFFFF, 1'b0);
    repeat (WAIT) @(posedge sys_clk);
    xfer(8'h48, 6'h18, 32'h0, 1'b0);
    chk(rdat[23:0], asp_pkg::MODE_RESET);
    chk(conv_run, 1'b1);
    finish_test();
  end
endmodule // tb_top
